// File: rtl/tcpr_pkg.sv
package tcpr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MANUAL = 8'h09;
  localparam logic [7:0] OFS_SWRESET = 8'h0A;
  localparam logic [7:0] OFS_MASK_PRI = 8'h0E;
  localparam logic [7:0] OFS_MASK_SEC = 8'h0F;
  localparam logic [7:0] OFS_STAT_PRI = 8'h11;
  localparam logic [7:0] OFS_STAT_SEC = 8'h12;
  localparam logic [7:0] OFS_FLAG_PRI = 8'h14;
  localparam logic [7:0] OFS_FLAG_SEC = 8'h15;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int BIT_FORCE_SOURCE = 5;
  localparam int BIT_FORCE_SINK = 4;
  localparam int BIT_UNATTACHED_SINK = 3;
  localparam int BIT_UNATTACHED_SOURCE = 2;
  localparam int BIT_HOLD_DIS = 1;
  localparam int BIT_ERR_REC = 0;
  localparam int BIT_SW_RESET = 0;
  localparam logic [7:0] MANUAL_WMASK = 8'h3F;
  localparam logic [7:0] MANUAL_ONESHOT = 8'h3D;
  localparam logic [7:0] PRI_VALID = 8'h7F;
  localparam logic [7:0] SEC_VALID = 8'h6F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic weak_battery_sink_active;
    logic vbus_below_safe_zero;
    logic [1:0] orientation;
    logic vbus_in_range;
    logic [1:0] advertised_current_level;
    logic attached;
  } tcpr_stat_pri_t;

  typedef struct packed {
    logic cc_fault;
    logic remedy_active;
  } tcpr_stat_sec_t;

  typedef struct packed {
    logic force_source_cmd;
    logic force_sink_cmd;
    logic goto_unattached_sink_cmd;
    logic goto_unattached_source_cmd;
    logic error_recovery_cmd;
  } tcpr_cmd_t;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'b00001,
    BUS_ADDR = 5'b00010,
    BUS_REG = 5'b00100,
    BUS_WR = 5'b01000,
    BUS_RD = 5'b10000
  } tcpr_bus_t;

  typedef struct packed {
    logic [7:0] manual;
    logic [7:0] mask_pri;
    logic [7:0] mask_sec;
    logic [7:0] flag_pri;
    logic [7:0] flag_sec;
    logic [7:0] stat_pri;
    logic [7:0] stat_sec;
    logic portrole_pending;
  } tcpr_regs_t;

endpackage : tcpr_pkg

// File: rtl/tcpr_port_regs.sv
`timescale 1ns/10ps
// How it works
// - Writing manual bit 5 forces Source behaviour; bit self-clears.
// - Writing manual bit 4 forces Sink behaviour; bit self-clears.
// - Bits 3 and 2 go to Unattached sink and source; both self-clear.
// - Bit 1 is plain read/write; while set the port is held disabled.
// - Writing bit 0 enters error recovery; bit self-clears.
// - Priority: disabled, error recovery, force source, force sink, unattached source, sink.
// - Only the winning command runs; all other set bits except bit 1 are cleared.
// - Disabled overrides port role; new role applies once disabled clears.
// - A port-role change cancels every pending manual command except disabled.
// - Software reset bit resets the controller and registers, then self-clears.
// - Primary mask bits 6..0 block their sources from the interrupt pin.
// - Secondary mask bits 6,5,3..0 block their sources from the pin.
// - Masked events still set flags; pin releases when no unmasked flag pends.
// - Status bit 7 shows weak-battery automatic sink active.
// - Status bit 6 shows VBUS below safe zero, bit 3 VBUS valid.
// - Status bits 5:4 report cable orientation or detection fault.
// - Status bits 2:1 report the advertised current level.
// - Status bit 0 shows the port is attached.
// - Secondary status bit 1 shows sink CC beyond the Rd window.
// - Secondary status bit 0 shows recovery methods running.
// - Manual, reset, mask and status registers reset to zero.
// - Flags clear per bit on written one; zero leaves them alone.
// - Global interrupt mask suppresses all interrupts at the pin.
module tcpr_port_regs
  import tcpr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h21
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Serial register port
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  output logic int_n,
  // Port logic state
  input wire tcpr_pkg::tcpr_stat_pri_t status_primary,
  input wire tcpr_pkg::tcpr_stat_sec_t status_secondary,
  input wire logic [7:0] irq_events_pri,
  input wire logic [7:0] irq_events_sec,
  input wire logic portrole_write,
  input wire logic global_int_mask,
  // Commands to the port state machine
  output tcpr_pkg::tcpr_cmd_t port_cmd,
  output logic hold_disabled,
  output logic portrole_apply,
  output logic controller_reset
);
  import tcpr_pkg::*;

  typedef struct packed {
    tcpr_regs_t regs;
    tcpr_bus_t bus;
    logic [3:0] bitcnt;
    logic ack;
    logic rw;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_out;
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    tcpr_cmd_t cmd;
    logic hold_disabled;
    logic portrole_apply;
    logic ctrl_reset;
    logic int_n;
  } tcpr_state_t;

  tcpr_state_t s;
  tcpr_state_t s_n;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_val;
  logic [7:0] pend;
  logic irq_pending;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] tcpr_read(input tcpr_regs_t r, input logic [7:0] ofs);
    logic [7:0] v;
    v = 8'h00;
    unique case (ofs)
      OFS_MANUAL: v = r.manual;
      OFS_MASK_PRI: v = r.mask_pri;
      OFS_MASK_SEC: v = r.mask_sec;
      OFS_STAT_PRI: v = r.stat_pri;
      OFS_STAT_SEC: v = r.stat_sec;
      OFS_FLAG_PRI: v = r.flag_pri;
      OFS_FLAG_SEC: v = r.flag_sec;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : tcpr_read

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_n = s;
    wr_en = 1'b0;
    wr_addr = s.ptr;
    wr_data = s.shift;
    rd_val = tcpr_read(s.regs, s.ptr);
    s_n.scl_s1 = i2c_scl;
    s_n.scl_s2 = s.scl_s1;
    s_n.scl_d = s.scl_s2;
    s_n.sda_s1 = i2c_sda_in;
    s_n.sda_s2 = s.sda_s1;
    s_n.sda_d = s.sda_s2;
    s_n.sda_out = 1'b0;
    scl_rise = s.scl_s2 & ~s.scl_d;
    scl_fall = ~s.scl_s2 & s.scl_d;
    bus_start = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
    bus_stop = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;

    // Serial byte engine
    if (bus_start)
    begin
      s_n.bus = BUS_ADDR;
      s_n.bitcnt = 4'h0;
      s_n.ack = 1'b0;
      s_n.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      s_n.bus = BUS_IDLE;
      s_n.ack = 1'b0;
      s_n.sda_oe = 1'b0;
    end
    else
    begin
      unique case (s.bus)
        BUS_IDLE:
        begin
          s_n.sda_oe = 1'b0;
        end
        BUS_ADDR, BUS_REG, BUS_WR:
        begin
          if (scl_rise && !s.ack && s.bitcnt != BITS_PER_BYTE)
          begin
            s_n.shift = {s.shift[6:0], s.sda_s2};
            s_n.bitcnt = s.bitcnt + 4'h1;
          end
          else if (scl_fall && !s.ack && s.bitcnt == BITS_PER_BYTE)
          begin
            if (s.bus == BUS_ADDR && s.shift[7:1] != DEV_ADDR)
            begin
              s_n.bus = BUS_IDLE;
            end
            else
            begin
              s_n.ack = 1'b1;
              s_n.sda_oe = 1'b1;
              if (s.bus == BUS_ADDR)
              begin
                s_n.rw = s.shift[0];
              end
              if (s.bus == BUS_REG)
              begin
                s_n.ptr = s.shift;
              end
              if (s.bus == BUS_WR)
              begin
                wr_en = 1'b1;
                s_n.ptr = s.ptr + 8'h01;
              end
            end
          end
          else if (scl_fall && s.ack)
          begin
            s_n.ack = 1'b0;
            s_n.sda_oe = 1'b0;
            s_n.bitcnt = 4'h0;
            if (s.bus == BUS_ADDR && s.rw)
            begin
              s_n.bus = BUS_RD;
              s_n.shift = rd_val;
              s_n.ptr = s.ptr + 8'h01;
              s_n.sda_oe = ~rd_val[7];
            end
            else if (s.bus == BUS_ADDR)
            begin
              s_n.bus = BUS_REG;
            end
            else
            begin
              s_n.bus = BUS_WR;
            end
          end
        end
        BUS_RD:
        begin
          if (scl_rise && s.bitcnt != BITS_PER_BYTE)
          begin
            s_n.bitcnt = s.bitcnt + 4'h1;
          end
          else if (scl_rise)
          begin
            if (s.sda_s2)
            begin
              s_n.bus = BUS_IDLE;
            end
            else
            begin
              s_n.ack = 1'b1;
            end
          end
          else if (scl_fall && s.ack)
          begin
            s_n.ack = 1'b0;
            s_n.bitcnt = 4'h0;
            s_n.shift = rd_val;
            s_n.ptr = s.ptr + 8'h01;
            s_n.sda_oe = ~rd_val[7];
          end
          else if (scl_fall && s.bitcnt == BITS_PER_BYTE)
          begin
            s_n.sda_oe = 1'b0;
          end
          else if (scl_fall)
          begin
            s_n.sda_oe = ~s.shift[3'(4'd7 - s.bitcnt)];
          end
        end
      endcase
    end

    // Status snapshot
    s_n.regs.stat_pri = status_primary;
    s_n.regs.stat_sec = {6'h00, status_secondary};

    // Flags: set wins over a written one
    s_n.regs.flag_pri = (s.regs.flag_pri | irq_events_pri) & PRI_VALID;
    s_n.regs.flag_sec = (s.regs.flag_sec | irq_events_sec) & SEC_VALID;
    if (wr_en && wr_addr == OFS_FLAG_PRI)
    begin
      s_n.regs.flag_pri = ((s.regs.flag_pri & ~wr_data) | irq_events_pri) & PRI_VALID;
    end
    if (wr_en && wr_addr == OFS_FLAG_SEC)
    begin
      s_n.regs.flag_sec = ((s.regs.flag_sec & ~wr_data) | irq_events_sec) & SEC_VALID;
    end

    // Manual command resolution, one cycle after the write
    s_n.cmd = '0;
    s_n.portrole_apply = 1'b0;
    s_n.ctrl_reset = 1'b0;
    pend = s.regs.manual & MANUAL_ONESHOT;
    if (|pend)
    begin
      s_n.regs.manual = s.regs.manual & ~MANUAL_ONESHOT;
      if (!s.regs.manual[BIT_HOLD_DIS] && !portrole_write)
      begin
        if (pend[BIT_ERR_REC])
          s_n.cmd.error_recovery_cmd = 1'b1;
        else if (pend[BIT_FORCE_SOURCE])
          s_n.cmd.force_source_cmd = 1'b1;
        else if (pend[BIT_FORCE_SINK])
          s_n.cmd.force_sink_cmd = 1'b1;
        else if (pend[BIT_UNATTACHED_SOURCE])
          s_n.cmd.goto_unattached_source_cmd = 1'b1;
        else
          s_n.cmd.goto_unattached_sink_cmd = 1'b1;
      end
    end
    if (wr_en && wr_addr == OFS_MANUAL)
    begin
      s_n.regs.manual = wr_data & MANUAL_WMASK;
    end
    s_n.hold_disabled = s.regs.manual[BIT_HOLD_DIS];

    // Port-role changes wait for the disabled hold to drop
    if (portrole_write && s.regs.manual[BIT_HOLD_DIS])
    begin
      s_n.regs.portrole_pending = 1'b1;
    end
    else if (portrole_write || (s.regs.portrole_pending && !s.regs.manual[BIT_HOLD_DIS]))
    begin
      s_n.regs.portrole_pending = 1'b0;
      s_n.portrole_apply = 1'b1;
    end

    // Masks
    if (wr_en && wr_addr == OFS_MASK_PRI)
    begin
      s_n.regs.mask_pri = wr_data & PRI_VALID;
    end
    if (wr_en && wr_addr == OFS_MASK_SEC)
    begin
      s_n.regs.mask_sec = wr_data & SEC_VALID;
    end

    // Interrupt pin
    irq_pending = (|(s.regs.flag_pri & ~s.regs.mask_pri)) | (|(s.regs.flag_sec & ~s.regs.mask_sec));
    s_n.int_n = ~(irq_pending & ~global_int_mask);

    // Software reset overrides everything in the register file
    if (wr_en && wr_addr == OFS_SWRESET && wr_data[BIT_SW_RESET])
    begin
      s_n.regs = '0;
      s_n.cmd = '0;
      s_n.portrole_apply = 1'b0;
      s_n.ctrl_reset = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.bus <= BUS_IDLE;
      s.int_n <= 1'b1;
      s.scl_s1 <= 1'b1;
      s.scl_s2 <= 1'b1;
      s.scl_d <= 1'b1;
      s.sda_s1 <= 1'b1;
      s.sda_s2 <= 1'b1;
      s.sda_d <= 1'b1;
    end
    else
    begin
      s <= s_n;
    end
  end

  assign i2c_sda_out = s.sda_out;
  assign i2c_sda_oe = s.sda_oe;
  assign int_n = s.int_n;
  assign port_cmd = s.cmd;
  assign hold_disabled = s.hold_disabled;
  assign portrole_apply = s.portrole_apply;
  assign controller_reset = s.ctrl_reset;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_disabled_blocks;
    @(posedge mclk) disable iff (!rstn)
    hold_disabled |-> port_cmd == '0;
  endproperty
  a_disabled_blocks: assert property (p_disabled_blocks) else $error("command issued while disabled");

  property p_one_winner;
    @(posedge mclk) disable iff (!rstn)
    ((s.regs.manual & MANUAL_ONESHOT) != 8'h00 && !wr_en)
      |=> $onehot0(port_cmd) && (s.regs.manual & MANUAL_ONESHOT) == 8'h00;
  endproperty
  a_one_winner: assert property (p_one_winner) else $error("more than one command or bits kept");

  property p_force_source_cmd;
    @(posedge mclk) disable iff (!rstn)
    (s.regs.manual[5:0] == 6'h20 && !portrole_write && !wr_en) |=> port_cmd.force_source_cmd ##1 !s.regs.manual[5];
  endproperty
  a_force_source_cmd: assert property (p_force_source_cmd) else $error("force source not executed");

  property p_priority;
    @(posedge mclk) disable iff (!rstn)
    (s.regs.manual[5:0] == 6'h3D && !portrole_write && !wr_en)
      |=> port_cmd.error_recovery_cmd && !port_cmd.force_sink_cmd;
  endproperty
  a_priority: assert property (p_priority) else $error("error recovery lost priority");

  property p_role_cancels;
    @(posedge mclk) disable iff (!rstn)
    portrole_write |=> port_cmd == '0;
  endproperty
  a_role_cancels: assert property (p_role_cancels) else $error("command survived role change");

  property p_role_waits;
    @(posedge mclk) disable iff (!rstn)
    (portrole_write && s.regs.manual[BIT_HOLD_DIS]) |=> !portrole_apply;
  endproperty
  a_role_waits: assert property (p_role_waits) else $error("role applied while disabled");

  property p_int_pin;
    @(posedge mclk) disable iff (!rstn)
    (irq_pending && !global_int_mask) |=> !int_n;
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("unmasked flag did not assert pin");

  property p_global_mask;
    @(posedge mclk) disable iff (!rstn)
    global_int_mask |=> int_n;
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("pin asserted under global mask");

  property p_swreset;
    @(posedge mclk) disable iff (!rstn)
    (wr_en && wr_addr == OFS_SWRESET && wr_data[0])
      |=> controller_reset && s.regs.mask_pri == 8'h00 ##1 !controller_reset;
  endproperty
  a_swreset: assert property (p_swreset) else $error("software reset not applied");

  property p_flag_set_wins;
    @(posedge mclk) disable iff (!rstn)
    (irq_events_pri[0] && !(wr_en && wr_addr == OFS_SWRESET)) |=> s.regs.flag_pri[0];
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("event lost against clear");

endmodule : tcpr_port_regs

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import tcpr_pkg::*;
  // Arbitrary device address
  localparam logic [6:0] DEV = 7'h21;
  logic mclk, rstn, scl, sda_pull, sda_line, sda_out, sda_oe, int_n, role_wr, gmask, hold, apply, creset, nak;
  tcpr_stat_pri_t stat_pri;
  tcpr_stat_sec_t stat_sec;
  tcpr_cmd_t port_cmd, cmd_seen;
  logic [7:0] ev_pri, ev_sec, d, p;
  int n_fail, checks, n_cmd, n_apply, n_rst;
  logic [7:0] offs [7] = '{OFS_MANUAL, OFS_SWRESET, OFS_MASK_PRI, OFS_MASK_SEC, OFS_STAT_PRI, OFS_STAT_SEC, 8'h3F};
  logic [12:0] cmd_tab [9] = '{{8'h20, 5'h10}, {8'h10, 5'h08}, {8'h08, 5'h04}, {8'h04, 5'h02}, {8'h01, 5'h01},
    {8'h3D, 5'h01}, {8'h3C, 5'h10}, {8'h18, 5'h08}, {8'h0C, 5'h02}};

  // Open-drain line with pull-up
  assign sda_line = ~(sda_pull | sda_oe);

  tcpr_port_regs #(.DEV_ADDR(DEV)) uut (.mclk(mclk), .rstn(rstn), .i2c_scl(scl), .i2c_sda_in(sda_line),
    .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe), .int_n(int_n), .status_primary(stat_pri),
    .status_secondary(stat_sec), .irq_events_pri(ev_pri), .irq_events_sec(ev_sec), .portrole_write(role_wr),
    .global_int_mask(gmask), .port_cmd(port_cmd), .hold_disabled(hold), .portrole_apply(apply),
    .controller_reset(creset));

  tcpr_host_model #(.DEV(DEV)) host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Output event counters
  always @(posedge mclk)
  begin
    if (port_cmd !== '0)
    begin
      cmd_seen = cmd_seen | port_cmd;
      n_cmd++;
    end
    if (apply === 1'b1)
      n_apply++;
    if (creset === 1'b1)
      n_rst++;
  end

  // --------
  // Helpers
  // --------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    host.write_reg(DEV, ofs, v, nak);
    check("write ack", {7'h0, nak}, 8'h00);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] ofs, input logic [7:0] exp);
    host.read_reg(ofs, d, nak);
    check("read ack", {7'h0, nak}, 8'h00);
    check(what, d, exp);
  endtask : rdc

  task automatic fire_events(input logic [7:0] a, input logic [7:0] b);
    @(negedge mclk);
    ev_pri = a;
    ev_sec = b;
    @(negedge mclk);
    ev_pri = 8'h00;
    ev_sec = 8'h00;
    host.tick(3);
  endtask : fire_events

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (90000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end

  // ------
  // Tests
  // ------
  initial
  begin
    rstn = 1'b0;
    stat_pri = '0;
    stat_sec = '0;
    ev_pri = 8'h00;
    ev_sec = 8'h00;
    role_wr = 1'b0;
    gmask = 1'b0;
    cmd_seen = '0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    host.tick(4);
    check("int_n", {7'h0, int_n}, 8'h01);
    check("sda_out", {7'h0, sda_out}, 8'h00);
    foreach (offs[i])
      rdc("reset value", offs[i], 8'h00);
    wr(OFS_MASK_PRI, 8'hFF);
    rdc("mask_pri", OFS_MASK_PRI, 8'h7F);
    wr(OFS_MASK_SEC, 8'hFF);
    rdc("mask_sec", OFS_MASK_SEC, 8'h6F);
    wr(OFS_MASK_PRI, 8'h00);
    wr(OFS_MASK_SEC, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      p = i ? 8'h5A : 8'hA5;
      @(negedge mclk);
      stat_pri = tcpr_stat_pri_t'(p);
      stat_sec = tcpr_stat_sec_t'(p[1:0]);
      rdc("stat_pri", OFS_STAT_PRI, p);
      rdc("stat_sec", OFS_STAT_SEC, {6'h00, p[1:0]});
    end
    foreach (cmd_tab[i])
    begin
      cmd_seen = '0;
      n_cmd = 0;
      wr(OFS_MANUAL, cmd_tab[i][12:5]);
      check("cmd", {3'h0, cmd_seen}, {3'h0, cmd_tab[i][4:0]});
      check("cmd count", 8'(n_cmd), 8'h01);
      rdc("manual", OFS_MANUAL, 8'h00);
    end
    n_cmd = 0;
    n_apply = 0;
    wr(OFS_MANUAL, 8'h02);
    check("hold", {7'h0, hold}, 8'h01);
    wr(OFS_MANUAL, 8'h23);
    check("cmd count", 8'(n_cmd), 8'h00);
    rdc("manual", OFS_MANUAL, 8'h02);
    @(negedge mclk);
    role_wr = 1'b1;
    @(negedge mclk);
    role_wr = 1'b0;
    host.tick(4);
    check("apply count", 8'(n_apply), 8'h00);
    wr(OFS_MANUAL, 8'h00);
    check("hold", {7'h0, hold}, 8'h00);
    check("apply count", 8'(n_apply), 8'h01);
    n_cmd = 0;
    n_apply = 0;
    // Role change lands in the resolve cycle after the data ack
    fork
      wr(OFS_MANUAL, 8'h20);
      begin
        repeat (3) @(posedge sda_oe);
        @(negedge mclk);
        role_wr = 1'b1;
        @(negedge mclk);
        role_wr = 1'b0;
      end
    join
    check("cmd count", 8'(n_cmd), 8'h00);
    check("apply count", 8'(n_apply), 8'h01);
    rdc("manual", OFS_MANUAL, 8'h00);
    fire_events(8'h01, 8'h00);
    check("int_n", {7'h0, int_n}, 8'h00);
    wr(OFS_MASK_PRI, 8'h01);
    check("int_n", {7'h0, int_n}, 8'h01);
    rdc("flag_pri", OFS_FLAG_PRI, 8'h01);
    wr(OFS_MASK_PRI, 8'h00);
    check("int_n", {7'h0, int_n}, 8'h00);
    @(negedge mclk);
    gmask = 1'b1;
    host.tick(3);
    check("int_n", {7'h0, int_n}, 8'h01);
    gmask = 1'b0;
    wr(OFS_FLAG_PRI, 8'h00);
    rdc("flag_pri", OFS_FLAG_PRI, 8'h01);
    wr(OFS_FLAG_PRI, 8'h01);
    check("int_n", {7'h0, int_n}, 8'h01);
    wr(OFS_MASK_SEC, 8'h08);
    fire_events(8'h80, 8'h98);
    check("int_n", {7'h0, int_n}, 8'h01);
    rdc("flag_pri", OFS_FLAG_PRI, 8'h00);
    rdc("flag_sec", OFS_FLAG_SEC, 8'h08);
    wr(OFS_MASK_SEC, 8'h00);
    check("int_n", {7'h0, int_n}, 8'h00);
    wr(OFS_FLAG_SEC, 8'h08);
    check("int_n", {7'h0, int_n}, 8'h01);
    wr(OFS_MASK_PRI, 8'h55);
    n_rst = 0;
    wr(OFS_SWRESET, 8'h01);
    check("reset count", 8'(n_rst), 8'h01);
    rdc("mask_pri", OFS_MASK_PRI, 8'h00);
    rdc("swreset", OFS_SWRESET, 8'h00);
    host.write_reg(DEV ^ 7'h01, OFS_MASK_PRI, 8'h11, nak);
    check("foreign address nack", {7'h0, nak}, 8'h01);
    rdc("mask_pri", OFS_MASK_PRI, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top

// File: verification/tcpr_host_model.sv
`timescale 1ns/10ps
module tcpr_host_model
#(
  parameter logic [6:0] DEV = 7'h21
)
(
  // Clock
  input wire logic mclk,
  // Bus wires
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ----------
  // Bit level
  // ----------
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  // Data moves two cycles after clock falls
  task automatic bit_slot(input logic b, output logic seen);
    sda_pull = ~b;
    tick(6);
    scl = 1'b1;
    tick(4);
    seen = sda_line;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : bit_slot

  task automatic start_cond();
    sda_pull = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask : start_cond

  task automatic stop_cond();
    sda_pull = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask : stop_cond

  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(tx[i], rx[i]);
    end
    bit_slot(ack_in, ack_out);
  endtask : xfer

  // -------------
  // Register ops
  // -------------
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] data, output logic nak);
    logic [7:0] rx;
    logic [2:0] a;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, rx, a[0]);
    xfer(ofs, 1'b1, rx, a[1]);
    xfer(data, 1'b1, rx, a[2]);
    stop_cond();
    nak = |a;
  endtask : write_reg

  // Single data byte, closed by a nack
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] data, output logic nak);
    logic [7:0] rx;
    logic [2:0] a;
    logic last;
    start_cond();
    xfer({DEV, 1'b0}, 1'b1, rx, a[0]);
    xfer(ofs, 1'b1, rx, a[1]);
    start_cond();
    xfer({DEV, 1'b1}, 1'b1, rx, a[2]);
    xfer(8'hFF, 1'b1, data, last);
    stop_cond();
    nak = |a;
  endtask : read_reg
endmodule : tcpr_host_model
